// >>> design/mlmco_pkg.sv
package mlmco_pkg;

    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 8;
    localparam int PC_W     = 13;
    localparam int BIT_W    = 3;
    localparam int NIB_W    = 4;
    localparam int PRESC_W  = 8;
    localparam int WDCNT_W  = 8;

    localparam logic [NIB_W-1:0]   BCD_LIMIT   = 4'h9;
    localparam logic [NIB_W-1:0]   BCD_ADJUST  = 4'h6;
    localparam logic [DATA_W-1:0]  BYTE_ZERO   = 8'h00;
    localparam logic [PC_W-1:0]    PC_RESET    = 13'h0000;
    localparam logic [PC_W-1:0]    PC_STEP     = 13'h0001;
    localparam logic [DATA_W-1:0]  BYTE_ONE    = 8'h01;
    localparam logic [PRESC_W-1:0] PRESC_RESET = 8'h00;
    localparam logic [PRESC_W-1:0] PRESC_LAST  = 8'hff;
    localparam logic [WDCNT_W-1:0] WDCNT_RESET = 8'h00;
    localparam logic [WDCNT_W-1:0] WDCNT_LAST  = 8'hff;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_READ   = 2'h1,
        ST_EXEC   = 2'h3,
        ST_HALTED = 2'h2
    } mlmco_state_t;

    typedef enum logic [4:0] {
        OP_NOP              = 5'h00,
        OP_AND_MEM          = 5'h01,
        OP_AND_IMM          = 5'h02,
        OP_AND_TO_MEMORY    = 5'h03,
        OP_OR_MEM           = 5'h04,
        OP_OR_IMM           = 5'h05,
        OP_OR_TO_MEMORY     = 5'h06,
        OP_INVERT_MEMORY    = 5'h07,
        OP_INVERT_TO_WORK   = 5'h08,
        OP_INCREMENT        = 5'h09,
        OP_INCREMENT_TO_WORK= 5'h0a,
        OP_DECREMENT        = 5'h0b,
        OP_DECREMENT_TO_WORK= 5'h0c,
        OP_BCD_ADJUST       = 5'h0d,
        OP_CLEAR_BYTE       = 5'h0e,
        OP_CLEAR_BIT        = 5'h0f,
        OP_MOVE_MEM_TO_WORK = 5'h10,
        OP_MOVE_IMM_TO_WORK = 5'h11,
        OP_MOVE_WORK_TO_MEM = 5'h12,
        OP_JUMP             = 5'h13,
        OP_CALL             = 5'h14,
        OP_GUARD_CLEAR      = 5'h15,
        OP_FIRST_PRECLEAR   = 5'h16,
        OP_SECOND_PRECLEAR  = 5'h17,
        OP_POWER_DOWN       = 5'h18
    } mlmco_op_t;

endpackage : mlmco_pkg

// >>> design/mlmco_watchdog.sv
`timescale 1ns/100ps
module mlmco_watchdog
    import mlmco_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    input  wire logic               clearReq,
    output logic [WDCNT_W-1:0]      countQ,
    output logic                    overflowQ
);

    logic [PRESC_W-1:0] prescQ;
    logic [PRESC_W-1:0] prescD;
    logic [WDCNT_W-1:0] countD;
    logic               overflowD;
    wire                prescWrap = (prescQ == PRESC_LAST);
    wire                countWrap = (countQ == WDCNT_LAST);

    // Counter and prescaler both return to zero on a clear
    assign prescD    = clearReq ? PRESC_RESET : prescQ + PRESC_STEP_ONE();
    assign countD    = clearReq ? WDCNT_RESET : (prescWrap ? countQ + WDCNT_STEP_ONE() : countQ);
    assign overflowD = !clearReq && prescWrap && countWrap;

    function automatic logic [PRESC_W-1:0] PRESC_STEP_ONE();
        return {{(PRESC_W-1){1'b0}}, 1'b1};
    endfunction : PRESC_STEP_ONE

    function automatic logic [WDCNT_W-1:0] WDCNT_STEP_ONE();
        return {{(WDCNT_W-1){1'b0}}, 1'b1};
    endfunction : WDCNT_STEP_ONE

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prescQ    <= PRESC_RESET;
            countQ    <= WDCNT_RESET;
            overflowQ <= 1'b0;
        end else begin
            prescQ    <= prescD;
            countQ    <= countD;
            overflowQ <= overflowD;
        end
    end

endmodule : mlmco_watchdog

// >>> design/mlmco_exec.sv
`timescale 1ns/100ps
module mlmco_exec
    import mlmco_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    input  wire logic               instrValid,
    input  wire logic [4:0]         instrOp,
    input  wire logic [ADDR_W-1:0]  instrAddr,
    input  wire logic [DATA_W-1:0]  instrImm,
    input  wire logic [BIT_W-1:0]   instrBit,
    input  wire logic [PC_W-1:0]    instrTarget,
    input  wire logic [DATA_W-1:0]  memRdData,
    input  wire logic               statusLoad,
    input  wire logic               statusCarry,
    input  wire logic               statusHalfCarry,
    input  wire logic               wakePin,
    output logic                    readyQ,
    output logic                    doneQ,
    output logic                    memRdEnQ,
    output logic                    memWrEnQ,
    output logic [ADDR_W-1:0]       memAddrQ,
    output logic [DATA_W-1:0]       memWrDataQ,
    output logic [DATA_W-1:0]       workRegisterQ,
    output logic                    zeroFlagQ,
    output logic                    carryFlagQ,
    output logic                    halfCarryFlagQ,
    output logic                    powerDownFlagQ,
    output logic                    timeoutFlagQ,
    output logic [PC_W-1:0]         pcQ,
    output logic                    stackPushQ,
    output logic [PC_W-1:0]         stackDataQ,
    output logic                    sysClkOffQ,
    output logic [WDCNT_W-1:0]      watchdogCounterQ
);

    mlmco_state_t       stateQ;
    mlmco_state_t       stateD;
    mlmco_op_t          opQ;
    logic [DATA_W-1:0]  immQ;
    logic [BIT_W-1:0]   bitQ;
    logic [PC_W-1:0]    targetQ;
    logic               firstPreclearQ;
    logic               secondPreclearQ;
    logic [2:0]         wakeSyncQ;
    logic               wakeLevelQ;
    logic               watchdogOverflow;

    wire  take      = instrValid && readyQ;
    wire  inExec    = (stateQ == ST_EXEC);
    wire  mlmco_op_t takenOp = mlmco_op_t'(instrOp);
    wire  needsRead = (takenOp == OP_AND_MEM) || (takenOp == OP_AND_TO_MEMORY) ||
                      (takenOp == OP_OR_MEM) || (takenOp == OP_OR_TO_MEMORY) ||
                      (takenOp == OP_INVERT_MEMORY) || (takenOp == OP_INVERT_TO_WORK) ||
                      (takenOp == OP_INCREMENT) || (takenOp == OP_INCREMENT_TO_WORK) ||
                      (takenOp == OP_DECREMENT) || (takenOp == OP_DECREMENT_TO_WORK) ||
                      (takenOp == OP_CLEAR_BIT) || (takenOp == OP_MOVE_MEM_TO_WORK);

    // Wake pin passes three flops; a change counts once the last two agree
    wire  wakeAgree = (wakeSyncQ[1] == wakeSyncQ[2]);
    wire  wakeNow   = wakeAgree ? wakeSyncQ[2] : wakeLevelQ;

    // BCD adjust datapath
    wire  [NIB_W-1:0] lowNib     = workRegisterQ[3:0];
    wire  [NIB_W-1:0] highNib    = workRegisterQ[7:4];
    wire              lowAdjust  = (lowNib > BCD_LIMIT) || halfCarryFlagQ;
    wire  [NIB_W:0]   lowSum     = {1'b0, lowNib} + {1'b0, BCD_ADJUST};
    wire              nibCarry   = lowAdjust ? lowSum[NIB_W] : 1'b0;
    wire  [NIB_W-1:0] lowResult  = lowAdjust ? lowSum[NIB_W-1:0] : lowNib;
    wire  [NIB_W:0]   highCarried = {1'b0, highNib} + {{NIB_W{1'b0}}, nibCarry};
    wire              highAdjust = (highCarried > {1'b0, BCD_LIMIT}) || carryFlagQ;
    wire  [NIB_W:0]   highSum    = highCarried + {1'b0, BCD_ADJUST};
    wire  [NIB_W-1:0] highResult = highAdjust ? highSum[NIB_W-1:0] : highCarried[NIB_W-1:0];
    wire  [DATA_W-1:0] bcdResult = {highResult, lowResult};

    // Result selection
    wire  [DATA_W-1:0] bitMask   = BYTE_ONE << bitQ;
    logic [DATA_W-1:0] result;
    logic              toWork;
    logic              toMem;
    logic              touchZero;

    always_comb begin
        result    = BYTE_ZERO;
        toWork    = 1'b0;
        toMem     = 1'b0;
        touchZero = 1'b0;
        unique case (opQ)
            OP_AND_MEM: begin
                result = workRegisterQ & memRdData;
                toWork = 1'b1;
                touchZero = 1'b1;
            end
            OP_AND_IMM: begin
                result = workRegisterQ & immQ;
                toWork = 1'b1;
                touchZero = 1'b1;
            end
            OP_AND_TO_MEMORY: begin
                result = workRegisterQ & memRdData;
                toMem = 1'b1;
                touchZero = 1'b1;
            end
            OP_OR_MEM: begin
                result = workRegisterQ | memRdData;
                toWork = 1'b1;
                touchZero = 1'b1;
            end
            OP_OR_IMM: begin
                result = workRegisterQ | immQ;
                toWork = 1'b1;
                touchZero = 1'b1;
            end
            OP_OR_TO_MEMORY: begin
                result = workRegisterQ | memRdData;
                toMem = 1'b1;
                touchZero = 1'b1;
            end
            OP_INVERT_MEMORY, OP_INVERT_TO_WORK: begin
                result = ~memRdData;
                toMem = (opQ == OP_INVERT_MEMORY);
                toWork = (opQ == OP_INVERT_TO_WORK);
                touchZero = 1'b1;
            end
            OP_INCREMENT, OP_INCREMENT_TO_WORK: begin
                result = memRdData + BYTE_ONE;
                toMem = (opQ == OP_INCREMENT);
                toWork = (opQ == OP_INCREMENT_TO_WORK);
                touchZero = 1'b1;
            end
            OP_DECREMENT, OP_DECREMENT_TO_WORK: begin
                result = memRdData - BYTE_ONE;
                toMem = (opQ == OP_DECREMENT);
                toWork = (opQ == OP_DECREMENT_TO_WORK);
                touchZero = 1'b1;
            end
            OP_BCD_ADJUST: begin
                result = bcdResult;
                toMem = 1'b1;
            end
            OP_CLEAR_BYTE: begin
                result = BYTE_ZERO;
                toMem = 1'b1;
            end
            OP_CLEAR_BIT: begin
                result = memRdData & ~bitMask;
                toMem = 1'b1;
            end
            OP_MOVE_MEM_TO_WORK: begin
                result = memRdData;
                toWork = 1'b1;
            end
            OP_MOVE_IMM_TO_WORK: begin
                result = immQ;
                toWork = 1'b1;
            end
            OP_MOVE_WORK_TO_MEM: begin
                result = workRegisterQ;
                toMem = 1'b1;
            end
            default: begin
                result = BYTE_ZERO;
            end
        endcase
    end

    wire  execNow      = inExec;
    wire  isJump       = execNow && (opQ == OP_JUMP);
    wire  isCall       = execNow && (opQ == OP_CALL);
    wire  isHalt       = execNow && (opQ == OP_POWER_DOWN);
    wire  isGuardClear = execNow && (opQ == OP_GUARD_CLEAR);
    wire  isFirstPre   = execNow && (opQ == OP_FIRST_PRECLEAR);
    wire  isSecondPre  = execNow && (opQ == OP_SECOND_PRECLEAR);
    wire  pairDone     = (isFirstPre && secondPreclearQ) || (isSecondPre && firstPreclearQ);
    wire  flagClear    = isGuardClear || pairDone;
    wire  watchdogClr  = flagClear || isHalt;
    wire  [PC_W-1:0] pcNext = pcQ + PC_STEP;

    // State sequencing
    always_comb begin
        stateD = stateQ;
        unique case (stateQ)
            ST_IDLE:   if (take) stateD = needsRead ? ST_READ : ST_EXEC;
            ST_READ:   stateD = ST_EXEC;
            ST_EXEC:   stateD = (opQ == OP_POWER_DOWN) ? ST_HALTED : ST_IDLE;
            ST_HALTED: if (wakeNow) stateD = ST_IDLE;
        endcase
    end

    mlmco_watchdog u_watchdog (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .clearReq  (watchdogClr),
        .countQ    (watchdogCounterQ),
        .overflowQ (watchdogOverflow)
    );

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wakeSyncQ  <= 3'h0;
            wakeLevelQ <= 1'b0;
        end else begin
            wakeSyncQ  <= {wakeSyncQ[1:0], wakePin};
            wakeLevelQ <= wakeNow;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stateQ     <= ST_IDLE;
            opQ        <= OP_NOP;
            immQ       <= BYTE_ZERO;
            bitQ       <= 3'h0;
            targetQ    <= PC_RESET;
            memAddrQ   <= BYTE_ZERO;
            readyQ     <= 1'b1;
            memRdEnQ   <= 1'b0;
            doneQ      <= 1'b0;
            sysClkOffQ <= 1'b0;
        end else begin
            stateQ     <= stateD;
            readyQ     <= (stateD == ST_IDLE);
            memRdEnQ   <= take && needsRead;
            doneQ      <= inExec;
            sysClkOffQ <= (stateD == ST_HALTED);
            if (take) begin
                opQ      <= takenOp;
                immQ     <= instrImm;
                bitQ     <= instrBit;
                targetQ  <= instrTarget;
                memAddrQ <= instrAddr;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            workRegisterQ <= BYTE_ZERO;
            memWrEnQ      <= 1'b0;
            memWrDataQ    <= BYTE_ZERO;
            zeroFlagQ     <= 1'b0;
            carryFlagQ    <= 1'b0;
            halfCarryFlagQ <= 1'b0;
        end else begin
            memWrEnQ <= inExec && toMem;
            if (inExec && toMem) memWrDataQ <= result;
            if (inExec && toWork) workRegisterQ <= result;
            if (inExec && touchZero) zeroFlagQ <= (result == BYTE_ZERO);
            if (inExec && (opQ == OP_BCD_ADJUST) && highAdjust) begin
                carryFlagQ <= 1'b1;
            end else if (statusLoad) begin
                carryFlagQ <= statusCarry;
            end
            if (statusLoad) halfCarryFlagQ <= statusHalfCarry;
        end
    end

    // Program counter, stack and guard flags
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pcQ             <= PC_RESET;
            stackPushQ      <= 1'b0;
            stackDataQ      <= PC_RESET;
            firstPreclearQ  <= 1'b0;
            secondPreclearQ <= 1'b0;
            powerDownFlagQ  <= 1'b0;
            timeoutFlagQ    <= 1'b0;
        end else begin
            stackPushQ <= isCall;
            if (isCall) stackDataQ <= pcNext;
            if (isJump || isCall) begin
                pcQ <= targetQ;
            end else if (inExec) begin
                pcQ <= pcNext;
            end
            if (pairDone) begin
                firstPreclearQ  <= 1'b0;
                secondPreclearQ <= 1'b0;
            end else begin
                if (isFirstPre) firstPreclearQ <= 1'b1;
                if (isSecondPre) secondPreclearQ <= 1'b1;
            end
            if (isHalt) begin
                powerDownFlagQ <= 1'b1;
            end else if (flagClear) begin
                powerDownFlagQ <= 1'b0;
            end
            // A watchdog time-out in the same cycle as a clear still sets the flag
            if (watchdogOverflow) begin
                timeoutFlagQ <= 1'b1;
            end else if (flagClear || isHalt) begin
                timeoutFlagQ <= 1'b0;
            end
        end
    end

endmodule : mlmco_exec

// >>> test/mlmco_exec_sva.sv
`timescale 1ns/100ps
module mlmco_exec_sva
    import mlmco_pkg::*;
(
    input wire logic               sys_clk,
    input wire logic               nrst,
    input wire logic               instrValid,
    input wire logic [4:0]         instrOp,
    input wire logic [DATA_W-1:0]  instrImm,
    input wire logic [PC_W-1:0]    instrTarget,
    input wire logic               readyQ,
    input wire logic               doneQ,
    input wire logic               memWrEnQ,
    input wire logic [DATA_W-1:0]  memWrDataQ,
    input wire logic [DATA_W-1:0]  workRegisterQ,
    input wire logic               zeroFlagQ,
    input wire logic               carryFlagQ,
    input wire logic               powerDownFlagQ,
    input wire logic               timeoutFlagQ,
    input wire logic [PC_W-1:0]    pcQ,
    input wire logic               stackPushQ,
    input wire logic [PC_W-1:0]    stackDataQ,
    input wire logic               sysClkOffQ,
    input wire logic [WDCNT_W-1:0] watchdogCounterQ
);
    logic [4:0]        opQ;
    logic [DATA_W-1:0] immQ;
    logic [PC_W-1:0]   tgtQ;
    wire memZ  = opQ inside {OP_AND_TO_MEMORY, OP_OR_TO_MEMORY, OP_INVERT_MEMORY, OP_INCREMENT, OP_DECREMENT};
    wire workZ = opQ inside {OP_AND_MEM, OP_AND_IMM, OP_OR_MEM, OP_OR_IMM, OP_INVERT_TO_WORK,
                             OP_INCREMENT_TO_WORK, OP_DECREMENT_TO_WORK};
    wire keepF = opQ inside {OP_MOVE_MEM_TO_WORK, OP_MOVE_IMM_TO_WORK, OP_MOVE_WORK_TO_MEM, OP_CLEAR_BYTE,
                             OP_CLEAR_BIT, OP_JUMP, OP_CALL, OP_NOP};
    // Remember the instruction that was taken
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            opQ <= 5'h00;
            immQ <= 8'h00;
            tgtQ <= 13'h0000;
        end else if (instrValid && readyQ) begin
            opQ <= instrOp;
            immQ <= instrImm;
            tgtQ <= instrTarget;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    AST_CALL_PUSH: assert property (stackPushQ |-> doneQ && stackDataQ == $past(pcQ) + PC_STEP)
        else $error("call pushed a wrong return address");
    AST_SLEEP_ENTRY: assert property ($rose(sysClkOffQ) |-> powerDownFlagQ && !timeoutFlagQ &&
        watchdogCounterQ == WDCNT_RESET && pcQ == $past(pcQ) + PC_STEP)
        else $error("power down entry state wrong");
    AST_SLEEP_STILL: assert property (sysClkOffQ && $past(sysClkOffQ) |-> !readyQ && $stable(pcQ) &&
        $stable(workRegisterQ))
        else $error("activity during power down");
    AST_ZERO_MEM: assert property (doneQ && memZ |-> memWrEnQ && zeroFlagQ == (memWrDataQ == BYTE_ZERO))
        else $error("zero flag wrong for memory result");
    AST_ZERO_WORK: assert property (doneQ && workZ |-> zeroFlagQ == (workRegisterQ == BYTE_ZERO))
        else $error("zero flag wrong for work result");
    AST_FLAGS_KEPT: assert property (doneQ && keepF |-> $stable(zeroFlagQ) && $stable(carryFlagQ))
        else $error("flags changed by a flag-neutral operation");
    AST_CLEAR_BYTE: assert property (doneQ && opQ == OP_CLEAR_BYTE |-> memWrEnQ && memWrDataQ == BYTE_ZERO)
        else $error("clear byte did not write zero");
    AST_MOVE_IMM: assert property (doneQ && opQ == OP_MOVE_IMM_TO_WORK |-> workRegisterQ == immQ)
        else $error("immediate move wrong");
    AST_JUMP: assert property (doneQ && opQ == OP_JUMP |-> pcQ == tgtQ && !stackPushQ)
        else $error("jump target wrong or stack touched");
    AST_NOP: assert property (doneQ && opQ == OP_NOP |-> pcQ == $past(pcQ) + PC_STEP && !memWrEnQ &&
        $stable(workRegisterQ))
        else $error("no-operation changed state");
    AST_GUARD: assert property (doneQ && opQ == OP_GUARD_CLEAR |-> !powerDownFlagQ && !timeoutFlagQ &&
        watchdogCounterQ == WDCNT_RESET)
        else $error("guard clear incomplete");
    cover property (doneQ && opQ == OP_CALL);
    cover property ($rose(sysClkOffQ));
    cover property (doneQ && opQ == OP_SECOND_PRECLEAR);
    cover property (doneQ && opQ == OP_BCD_ADJUST && carryFlagQ);
endmodule : mlmco_exec_sva

bind mlmco_exec mlmco_exec_sva i_sva (.*);

// >>> test/mlmco_mem_model.sv
`timescale 1ns/100ps
module mlmco_mem_model (
    input  wire logic       sys_clk,
    input  wire logic       memRdEn,
    input  wire logic       memWrEn,
    input  wire logic [7:0] memAddr,
    input  wire logic [7:0] memWrData,
    output logic      [7:0] memRdData
);
    logic [7:0] mem [256];
    logic       holdQ;
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        memRdData = 8'h00;
        holdQ = 1'b0;
    end
    // Read word is held one extra cycle, then scrambled
    always @(posedge sys_clk) begin
        if (memWrEn) mem[memAddr] <= memWrData;
        if (memRdEn) begin
            memRdData <= mem[memAddr];
            holdQ <= 1'b1;
        end else if (holdQ) holdQ <= 1'b0;
        else memRdData <= ~memRdData;
    end
endmodule : mlmco_mem_model

// >>> test/test_mcu_logic_move_control_ops.sv
`timescale 1ns/100ps
module test_mcu_logic_move_control_ops;
    import mlmco_pkg::*;
    logic        sys_clk, nrst, instrValid, statusLoad, statusCarry, statusHalfCarry, wakePin;
    logic [4:0]  instrOp;
    logic [7:0]  instrAddr, instrImm, memRdData, memAddrQ, memWrDataQ, workRegisterQ, watchdogCounterQ;
    logic [2:0]  instrBit;
    logic [12:0] instrTarget, pcQ, stackDataQ;
    logic        readyQ, doneQ, memRdEnQ, memWrEnQ, zeroFlagQ, carryFlagQ, halfCarryFlagQ;
    logic        powerDownFlagQ, timeoutFlagQ, stackPushQ, sysClkOffQ, pushSeen;
    int          failures, checked, cycles;

    mlmco_exec i_dut (.sys_clk(sys_clk), .nrst(nrst), .instrValid(instrValid), .instrOp(instrOp),
        .instrAddr(instrAddr), .instrImm(instrImm), .instrBit(instrBit), .instrTarget(instrTarget),
        .memRdData(memRdData), .statusLoad(statusLoad), .statusCarry(statusCarry),
        .statusHalfCarry(statusHalfCarry), .wakePin(wakePin), .readyQ(readyQ), .doneQ(doneQ),
        .memRdEnQ(memRdEnQ), .memWrEnQ(memWrEnQ), .memAddrQ(memAddrQ), .memWrDataQ(memWrDataQ),
        .workRegisterQ(workRegisterQ), .zeroFlagQ(zeroFlagQ), .carryFlagQ(carryFlagQ),
        .halfCarryFlagQ(halfCarryFlagQ), .powerDownFlagQ(powerDownFlagQ), .timeoutFlagQ(timeoutFlagQ),
        .pcQ(pcQ), .stackPushQ(stackPushQ), .stackDataQ(stackDataQ), .sysClkOffQ(sysClkOffQ),
        .watchdogCounterQ(watchdogCounterQ));
    mlmco_mem_model i_mem (.sys_clk(sys_clk), .memRdEn(memRdEnQ), .memWrEn(memWrEnQ), .memAddr(memAddrQ),
        .memWrData(memWrDataQ), .memRdData(memRdData));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 3000) begin
            failures++;
            stop_test();
        end
    end

    task stop_test();
        if (failures == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Offer one instruction, wait for its completion; imm low bits double as bit index
    task run(input mlmco_op_t op, input logic [7:0] a, input logic [7:0] imm, input logic [12:0] t);
        int n;
        n = 0;
        pushSeen = 1'b0;
        @(posedge sys_clk);
        instrOp <= op;
        instrAddr <= a;
        instrImm <= imm;
        instrBit <= imm[2:0];
        instrTarget <= t;
        instrValid <= 1'b1;
        do @(posedge sys_clk); while (readyQ !== 1'b1 && ++n < 20);
        instrValid <= 1'b0;
        do begin
            @(posedge sys_clk);
            #1;
            pushSeen |= stackPushQ;
        end while (doneQ !== 1'b1 && ++n < 20);
        chk("done", doneQ, 1'b1);
        // Memory takes the write one edge after completion
        @(posedge sys_clk);
        #1;
    endtask : run

    task t_moves();
        run(OP_MOVE_IMM_TO_WORK, 8'h00, 8'h5a, 13'h0000);
        chk("work", workRegisterQ, 8'h5a);
        run(OP_MOVE_WORK_TO_MEM, 8'h10, 8'h00, 13'h0000);
        chk("mem", i_mem.mem[8'h10], 8'h5a);
        run(OP_MOVE_IMM_TO_WORK, 8'h00, 8'h00, 13'h0000);
        run(OP_MOVE_MEM_TO_WORK, 8'h10, 8'h00, 13'h0000);
        chk("work", workRegisterQ, 8'h5a);
        chk("zero", zeroFlagQ, 1'b0);
    endtask : t_moves

    task t_logic();
        run(OP_AND_IMM, 8'h00, 8'ha5, 13'h0000);
        chk("work", workRegisterQ, 8'h00);
        chk("zero", zeroFlagQ, 1'b1);
        run(OP_MOVE_IMM_TO_WORK, 8'h00, 8'h0f, 13'h0000);
        chk("zero", zeroFlagQ, 1'b1);
        run(OP_AND_MEM, 8'h10, 8'h00, 13'h0000);
        chk("work", workRegisterQ, 8'h0a);
        chk("zero", zeroFlagQ, 1'b0);
        run(OP_OR_IMM, 8'h00, 8'h50, 13'h0000);
        chk("work", workRegisterQ, 8'h5a);
        run(OP_MOVE_IMM_TO_WORK, 8'h00, 8'h0f, 13'h0000);
        run(OP_AND_TO_MEMORY, 8'h10, 8'h00, 13'h0000);
        chk("mem", i_mem.mem[8'h10], 8'h0a);
        chk("work", workRegisterQ, 8'h0f);
        run(OP_OR_TO_MEMORY, 8'h10, 8'h00, 13'h0000);
        chk("mem", i_mem.mem[8'h10], 8'h0f);
        run(OP_MOVE_IMM_TO_WORK, 8'h00, 8'h30, 13'h0000);
        run(OP_OR_MEM, 8'h10, 8'h00, 13'h0000);
        chk("work", workRegisterQ, 8'h3f);
        run(OP_INVERT_TO_WORK, 8'h10, 8'h00, 13'h0000);
        chk("work", workRegisterQ, 8'hf0);
        chk("mem", i_mem.mem[8'h10], 8'h0f);
        run(OP_INVERT_MEMORY, 8'h10, 8'h00, 13'h0000);
        chk("mem", i_mem.mem[8'h10], 8'hf0);
    endtask : t_logic

    task t_incdec();
        run(OP_MOVE_IMM_TO_WORK, 8'h00, 8'hff, 13'h0000);
        run(OP_MOVE_WORK_TO_MEM, 8'h20, 8'h00, 13'h0000);
        run(OP_INCREMENT, 8'h20, 8'h00, 13'h0000);
        chk("mem", i_mem.mem[8'h20], 8'h00);
        chk("zero", zeroFlagQ, 1'b1);
        run(OP_DECREMENT, 8'h20, 8'h00, 13'h0000);
        chk("mem", i_mem.mem[8'h20], 8'hff);
        chk("zero", zeroFlagQ, 1'b0);
        run(OP_INCREMENT_TO_WORK, 8'h10, 8'h00, 13'h0000);
        chk("work", workRegisterQ, 8'hf1);
        run(OP_DECREMENT_TO_WORK, 8'h10, 8'h00, 13'h0000);
        chk("work", workRegisterQ, 8'hef);
        chk("mem", i_mem.mem[8'h10], 8'hf0);
        run(OP_CLEAR_BIT, 8'h20, 8'h03, 13'h0000);
        chk("mem", i_mem.mem[8'h20], 8'hf7);
        run(OP_CLEAR_BYTE, 8'h20, 8'h00, 13'h0000);
        chk("mem", i_mem.mem[8'h20], 8'h00);
        chk("zero", zeroFlagQ, 1'b0);
    endtask : t_incdec

    task t_bcd(input logic c, input logic h, input logic [7:0] w, input logic [7:0] em, input logic ec);
        @(posedge sys_clk);
        statusLoad <= 1'b1;
        statusCarry <= c;
        statusHalfCarry <= h;
        @(posedge sys_clk);
        statusLoad <= 1'b0;
        run(OP_MOVE_IMM_TO_WORK, 8'h00, w, 13'h0000);
        run(OP_BCD_ADJUST, 8'h30, 8'h00, 13'h0000);
        chk("bcd", i_mem.mem[8'h30], em);
        chk("carry", carryFlagQ, ec);
        chk("hc", halfCarryFlagQ, h);
    endtask : t_bcd

    task t_branch();
        run(OP_JUMP, 8'h00, 8'h00, 13'h1abc);
        chk("pc", pcQ, 13'h1abc);
        chk("push", pushSeen, 1'b0);
        run(OP_CALL, 8'h00, 8'h00, 13'h0123);
        chk("pc", pcQ, 13'h0123);
        chk("push", pushSeen, 1'b1);
        chk("stack", stackDataQ, 13'h1abd);
        run(OP_NOP, 8'h00, 8'h00, 13'h0000);
        chk("pc", pcQ, 13'h0124);
    endtask : t_branch

    task t_sleep();
        int n;
        n = 0;
        run(OP_POWER_DOWN, 8'h00, 8'h00, 13'h0000);
        chk("pdf", powerDownFlagQ, 1'b1);
        chk("off", sysClkOffQ, 1'b1);
        chk("wdt", watchdogCounterQ, 8'h00);
        @(posedge sys_clk);
        wakePin <= 1'b1;
        do @(posedge sys_clk); while (readyQ !== 1'b1 && ++n < 20);
        wakePin <= 1'b0;
        chk("off", sysClkOffQ, 1'b0);
    endtask : t_sleep

    task t_guard();
        t_sleep();
        chk("pc", pcQ, 13'h0125);
        // Let the counter step once past a full prescaler round
        repeat (300) @(posedge sys_clk);
        run(OP_FIRST_PRECLEAR, 8'h00, 8'h00, 13'h0000);
        chk("pdf", powerDownFlagQ, 1'b1);
        chk("wdt", watchdogCounterQ, 8'h01);
        run(OP_SECOND_PRECLEAR, 8'h00, 8'h00, 13'h0000);
        chk("pdf", powerDownFlagQ, 1'b0);
        chk("to", timeoutFlagQ, 1'b0);
        chk("wdt", watchdogCounterQ, 8'h00);
        t_sleep();
        run(OP_GUARD_CLEAR, 8'h00, 8'h00, 13'h0000);
        chk("pdf", powerDownFlagQ, 1'b0);
        chk("wdt", watchdogCounterQ, 8'h00);
    endtask : t_guard

    initial begin
        {nrst, instrValid, statusLoad, statusCarry, statusHalfCarry, wakePin} = 6'h00;
        {instrOp, instrAddr, instrImm, instrBit, instrTarget} = 37'h0;
        failures = 0;
        checked = 0;
        cycles = 0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        t_moves();
        t_logic();
        t_incdec();
        t_bcd(1'b0, 1'b0, 8'h9b, 8'h01, 1'b1);
        t_bcd(1'b0, 1'b1, 8'h12, 8'h18, 1'b0);
        t_bcd(1'b1, 1'b0, 8'h12, 8'h72, 1'b1);
        t_bcd(1'b0, 1'b0, 8'h12, 8'h12, 1'b0);
        t_branch();
        t_guard();
        stop_test();
    end
endmodule : test_mcu_logic_move_control_ops
